// File: hdl/dbpp_pkg.sv
// Package with shared constants and types for the display bus port
// Functional notes
// RULE_01: Preset reset output low while preset held
// RULE_02: Instrument side drives preset low when pressed
// RULE_03: Preset reset follows buffered preset, same polarity
// RULE_04: Segment clear when preset or processor clear
// RULE_05: Segment clear pulses 1 ms every 4 ms
// RULE_06: Segment clear held low during preset
// RULE_07: Select strobe low 300 to 400 ns
// RULE_08: Five address bits decoded with select strobe
// RULE_09: Annunciator write gives one 300 ns strobe
// RULE_10: Display write gives one 300 ns strobe
// RULE_11: Interrupt strobe sets request until acknowledged
// RULE_12: Processor acknowledge pulses low for 700 ns
// RULE_13: Acknowledge low holds request latch cleared
// RULE_14: At most one strobe per access, none idle
package dbpp_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CLK_NS = 50;
    localparam int unsigned ADDR_W = 5;
    // Port addresses of the two decoded targets
    localparam logic [4:0] ANNUNCIATOR_ADDR = 5'h00;
    localparam logic [4:0] DISPLAY_ADDR = 5'h02;
    // Strobe and pulse times in ns, cycles derived
    localparam int unsigned STROBE_NS = 300;
    localparam int unsigned STROBE_CYC = STROBE_NS / CLK_NS;
    localparam int unsigned SELECT_NS = 350;
    localparam int unsigned SELECT_CYC = SELECT_NS / CLK_NS;
    localparam int unsigned ACK_NS = 700;
    localparam int unsigned ACK_CYC = ACK_NS / CLK_NS;
    // Clear train timing in us
    localparam int unsigned CLEAR_LOW_US = 1000;
    localparam int unsigned CLEAR_PERIOD_US = 4000;
    localparam int unsigned CLEAR_LOW_CYC = CLEAR_LOW_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CLEAR_PERIOD_CYC =
        CLEAR_PERIOD_US * (CLK_HZ / 1_000_000);
    // Reset values
    localparam logic RST_HIGH = 1'b1;
    typedef enum logic {DBPP_WR_IDLE, DBPP_WR_BUSY} dbpp_wr_t;
endpackage

// File: hdl/dbpp_if.sv
// Interface joining instrument side and display side
`timescale 1ns/1ps
interface dbpp_if;
    logic portSelect_n;
    logic [4:0] portAddr;
    logic instrumentPreset_n;
    modport device (
        input portSelect_n,
        input portAddr,
        input instrumentPreset_n
    );
    modport host (
        output portSelect_n,
        output portAddr,
        output instrumentPreset_n
    );
endinterface

// File: hdl/dbpp_device.sv
// Display side: address decode, service latch and preset logic
`timescale 1ns/1ps
module dbpp_device
    import dbpp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    dbpp_if.device bus,
    input wire logic requestAcknowledge_n,
    input wire logic processorClearPort_n,
    output logic presetReset_n,
    output logic segmentLatchClear_n,
    output logic annunciatorLoadStrobe_n,
    output logic interruptStrobe_n,
    output logic serviceRequest_n
);
    // Three-stage synchronisers for single-bit pins from the far side; address bus has two stages
    logic [2:0] selSync_q, presetSync_q, ackSync_q, clrSync_q;
    logic [4:0] addrSync1_q, addrSync2_q;
    logic sel_q, preset_q, ack_q, procClr_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            selSync_q <= 3'h7;
            presetSync_q <= 3'h7;
            ackSync_q <= 3'h7;
            clrSync_q <= 3'h7;
            addrSync1_q <= 5'h00;
            addrSync2_q <= 5'h00;
        end else begin
            selSync_q <= {selSync_q[1:0], bus.portSelect_n};
            presetSync_q <= {presetSync_q[1:0], bus.instrumentPreset_n};
            ackSync_q <= {ackSync_q[1:0], requestAcknowledge_n};
            clrSync_q <= {clrSync_q[1:0], processorClearPort_n};
            addrSync1_q <= bus.portAddr;
            addrSync2_q <= addrSync1_q;
        end
    end

    // Levels change only when stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_q <= 1'b1;
            preset_q <= 1'b1;
            ack_q <= 1'b1;
            procClr_q <= 1'b1;
        end else begin
            if (selSync_q[2] == selSync_q[1]) sel_q <= selSync_q[2];
            if (presetSync_q[2] == presetSync_q[1])
                preset_q <= presetSync_q[2];
            if (ackSync_q[2] == ackSync_q[1]) ack_q <= ackSync_q[2];
            if (clrSync_q[2] == clrSync_q[1]) procClr_q <= clrSync_q[2];
        end
    end

    // Preset reset mirrors the filtered preset level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            presetReset_n <= 1'b0;
        end else begin
            presetReset_n <= preset_q; // [RULE_01] [RULE_03]
        end
    end

    // Free-running clear train stands in for processor port when idle
    logic [16:0] trainCnt_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trainCnt_q <= 17'h0_0000;
        end else if (trainCnt_q == 17'(CLEAR_PERIOD_CYC - 1)) begin
            trainCnt_q <= 17'h0_0000; // [RULE_05]
        end else begin
            trainCnt_q <= trainCnt_q + 17'h0_0001;
        end
    end

    // Clear is low on preset, processor clear, or train low phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            segmentLatchClear_n <= 1'b0;
        end else begin
            segmentLatchClear_n <= preset_q && procClr_q // [RULE_04] [RULE_06]
                && (trainCnt_q >= 17'(CLEAR_LOW_CYC)); // [RULE_05]
        end
    end

    // Decode one strobe per select falling edge; address sampled then
    dbpp_wr_t wrState_q;
    logic [3:0] strobeCnt_q;
    logic selPrev_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            selPrev_q <= 1'b1;
        end else begin
            selPrev_q <= sel_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrState_q <= DBPP_WR_IDLE;
            strobeCnt_q <= 4'h0;
            annunciatorLoadStrobe_n <= 1'b1;
            interruptStrobe_n <= 1'b1;
        end else begin
            case (wrState_q)
                DBPP_WR_IDLE: begin
                    if (selPrev_q && !sel_q) begin // [RULE_08]
                        strobeCnt_q <= 4'(STROBE_CYC - 1);
                        wrState_q <= DBPP_WR_BUSY;
                        // Only one target can match [RULE_14]
                        if (addrSync2_q == ANNUNCIATOR_ADDR) begin
                            annunciatorLoadStrobe_n <= 1'b0; // [RULE_09]
                        end else if (addrSync2_q == DISPLAY_ADDR) begin
                            interruptStrobe_n <= 1'b0; // [RULE_10]
                        end
                    end
                end
                DBPP_WR_BUSY: begin
                    if (strobeCnt_q == 4'h0) begin
                        annunciatorLoadStrobe_n <= 1'b1;
                        interruptStrobe_n <= 1'b1;
                        wrState_q <= DBPP_WR_IDLE;
                    end else begin
                        strobeCnt_q <= strobeCnt_q - 4'h1;
                    end
                end
                default: wrState_q <= DBPP_WR_IDLE;
            endcase
        end
    end

    // Service latch: acknowledge low dominates and holds it clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serviceRequest_n <= 1'b1;
        end else if (!ack_q) begin
            serviceRequest_n <= 1'b1; // [RULE_13]
        end else if (!interruptStrobe_n) begin
            serviceRequest_n <= 1'b0; // [RULE_11]
        end
    end
endmodule // dbpp_device

// File: hdl/dbpp_host.sv
// Instrument side: generates select strobes and preset level
`timescale 1ns/1ps
module dbpp_host
    import dbpp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    dbpp_if.host bus,
    input wire logic accessReq,
    input wire logic [4:0] accessAddr,
    input wire logic presetKey,
    output logic accessBusy
);
    logic [3:0] selCnt_q;
    logic sel_n_q, preset_n_q;
    logic [4:0] addr_q;
    assign bus.portSelect_n = sel_n_q;
    assign bus.portAddr = addr_q;
    assign bus.instrumentPreset_n = preset_n_q;

    // Preset key pulls the line low while pressed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            preset_n_q <= 1'b1;
        end else begin
            preset_n_q <= !presetKey; // [RULE_02]
        end
    end

    // Address set up, then select low for a fixed 350 ns
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_n_q <= 1'b1;
            addr_q <= 5'h00;
            selCnt_q <= 4'h0;
            accessBusy <= 1'b0;
        end else if (!accessBusy) begin
            if (accessReq) begin
                addr_q <= accessAddr; // [RULE_08]
                accessBusy <= 1'b1;
                selCnt_q <= 4'(SELECT_CYC + 2);
            end
        end else if (selCnt_q == 4'h0) begin
            sel_n_q <= 1'b1;
            accessBusy <= 1'b0;
        end else begin
            selCnt_q <= selCnt_q - 4'h1;
            if (selCnt_q == 4'(SELECT_CYC)) sel_n_q <= 1'b0; // [RULE_07]
        end
    end
endmodule // dbpp_host

// File: dv/dbpp_checker.sv
// Assertions on the joined display bus port
`timescale 1ns/1ps
module dbpp_checker
    import dbpp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic portSelect_n,
    input wire logic [4:0] portAddr,
    input wire logic instrumentPreset_n,
    input wire logic requestAcknowledge_n,
    input wire logic processorClearPort_n,
    input wire logic presetReset_n,
    input wire logic segmentLatchClear_n,
    input wire logic annunciatorLoadStrobe_n,
    input wire logic interruptStrobe_n,
    input wire logic serviceRequest_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic forced;
    int clrLow_q;
    // Forced clears are not part of the train
    assign forced = !instrumentPreset_n || !processorClearPort_n;
    // Length of the unforced low run; sync delay needs slack
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clrLow_q <= 0;
        end else begin
            clrLow_q <= (segmentLatchClear_n || forced) ? 0 : clrLow_q + 1;
        end
    end
    // Six low cycles then high again
    sequence s_strobe(s);
        !s [*6] ##1 s;
    endsequence
    sequence s_ann_sel;
        $fell(portSelect_n) && portAddr == ANNUNCIATOR_ADDR;
    endsequence
    chk_ann_width: assert property (
        $fell(annunciatorLoadStrobe_n) |-> s_strobe(annunciatorLoadStrobe_n))
        else $error("annunciator strobe width wrong");
    chk_int_width: assert property (
        $fell(interruptStrobe_n) |-> s_strobe(interruptStrobe_n))
        else $error("interrupt strobe width wrong");
    chk_ann_cause: assert property (
        s_ann_sel |-> ##[3:8] $fell(annunciatorLoadStrobe_n))
        else $error("annunciator access gave no strobe");
    chk_one_strobe: assert property (
        annunciatorLoadStrobe_n || interruptStrobe_n)
        else $error("both strobes low");
    chk_irq_set: assert property (
        $fell(interruptStrobe_n) && requestAcknowledge_n
        |-> ##[0:3] !serviceRequest_n) else $error("request not set");
    chk_irq_clear: assert property (
        $rose(serviceRequest_n) |-> !requestAcknowledge_n)
        else $error("request dropped without acknowledge");
    chk_ack_blocks: assert property (
        !requestAcknowledge_n [*6] |-> serviceRequest_n)
        else $error("request while acknowledge low");
    chk_preset_low: assert property (
        !instrumentPreset_n [*6] |-> !presetReset_n && !segmentLatchClear_n)
        else $error("preset not forcing outputs low");
    chk_train_width: assert property (
        clrLow_q <= CLEAR_LOW_CYC + 40) else $error("clear pulse too long");
endmodule // dbpp_checker

// File: dv/display_bus_port_and_preset_bench.sv
// Bench driving both ends of the display bus port together
`timescale 1ns/1ps
module display_bus_port_and_preset_bench;
    import dbpp_pkg::*;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic accessReq = 1'h0;
    logic [4:0] accessAddr = 5'h00;
    logic presetKey = 1'h0;
    logic requestAcknowledge_n = 1'h1;
    logic processorClearPort_n = 1'h1;
    logic accessBusy;
    logic presetReset_n;
    logic segmentLatchClear_n;
    logic annunciatorLoadStrobe_n;
    logic interruptStrobe_n;
    logic serviceRequest_n;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    dbpp_if bus ();
    dbpp_host dbpp_host_i (.bus(bus.host), .*);
    dbpp_device dbpp_device_i (.bus(bus.device), .*);
    dbpp_checker dbpp_checker_i (.portSelect_n(bus.portSelect_n),
        .portAddr(bus.portAddr), .instrumentPreset_n(bus.instrumentPreset_n),
        .*);
    // 50 ns clock
    always #25 clk = ~clk;
    // Drive just after an edge so sampling never races
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One access, counting low cycles of each strobe
    task automatic access(input logic [4:0] a, output int nA, output int nI);
        nA = 0;
        nI = 0;
        accessAddr = a;
        accessReq = 1'h1;
        tick(1);
        accessReq = 1'h0;
        repeat (24) begin
            nA += (annunciatorLoadStrobe_n === 1'h0);
            nI += (interruptStrobe_n === 1'h0);
            tick(1);
        end
    endtask
    task automatic ack_pulse;
        requestAcknowledge_n = 1'h0;
        tick(ACK_CYC);
        requestAcknowledge_n = 1'h1;
        tick(10);
    endtask
    // Every address; only the two decoded ones may strobe
    task automatic t_decode;
        int nA;
        int nI;
        for (int a = 0; a < 32; a++) begin
            access(5'(a), nA, nI);
            check(nA, (a == ANNUNCIATOR_ADDR) ? 6 : 0);
            check(nI, (a == DISPLAY_ADDR) ? 6 : 0);
        end
        $display("decode test done");
    endtask
    // Request holds for 10 us, clears on acknowledge, blocked while low
    task automatic t_irq;
        int nA;
        int nI;
        ack_pulse();
        check(serviceRequest_n, 1'h1);
        access(DISPLAY_ADDR, nA, nI);
        tick(176);
        check(serviceRequest_n, 1'h0);
        ack_pulse();
        check(serviceRequest_n, 1'h1);
        requestAcknowledge_n = 1'h0;
        tick(8);
        access(DISPLAY_ADDR, nA, nI);
        check(serviceRequest_n, 1'h1);
        requestAcknowledge_n = 1'h1;
        tick(10);
        $display("request test done");
    endtask
    // Preset key forces both outputs low; processor clear forces only the segment clear
    // Called in the train's high phase, else forcing cannot show
    task automatic t_preset;
        presetKey = 1'h1;
        tick(10);
        check(presetReset_n, 1'h0);
        check(segmentLatchClear_n, 1'h0);
        tick(2000);
        check(segmentLatchClear_n, 1'h0);
        presetKey = 1'h0;
        tick(10);
        check(presetReset_n, 1'h1);
        check(segmentLatchClear_n, 1'h1);
        processorClearPort_n = 1'h0;
        tick(5);
        check(segmentLatchClear_n, 1'h0);
        processorClearPort_n = 1'h1;
        tick(10);
        check(segmentLatchClear_n, 1'h1);
        $display("preset test done");
    endtask
    // Mid-run reset restarts the train, so its phase is known
    task automatic t_train;
        int n;
        int start;
        rst = 1'h1;
        tick(2);
        rst = 1'h0;
        n = 0;
        while (segmentLatchClear_n === 1'h0 && n < 21000) begin
            tick(1);
            n++;
        end
        check(n > 19900 && n < 20100, 1'h1);
        start = cycles;
        t_preset();
        while (segmentLatchClear_n === 1'h1 && cycles - start < 61000) begin
            tick(1);
        end
        n = cycles - start;
        check(n > 59900 && n < 60100, 1'h1);
        $display("train test done");
    endtask
    task automatic results;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Ceiling on run length cuts a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            n_mismatch++;
            results();
        end
    end
    // Main sequence
    initial begin
        tick(8);
        rst = 1'h0;
        tick(10);
        check(presetReset_n, 1'h1);
        t_decode();
        t_irq();
        t_train();
        results();
    end
endmodule // display_bus_port_and_preset_bench
